// >>> design/psram_ctrl.sv
// host controller that drives an asynchronous page psram through its pins
`timescale 1ns/1ps
`default_nettype none
`include "psram_regs.svh"
module psram_ctrl (
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic             o_ce_n,
	output logic             o_we_n,
	output logic             o_oe_n,
	output logic             o_lower_byte_n,
	output logic             o_upper_byte_n,
	output logic             o_sleep_n,
	output logic      [20:0] o_mem_addr,
	output logic      [15:0] o_dq_out,
	output logic             o_dq_oe,
	input  wire logic [15:0] i_dq_in
);
	tmr_if t ();                                  // interval timer link

	psram_pkg::state_t state_r, state_nxt;        // sequencer state
	psram_pkg::kind_t  kind_r, kind_nxt;          // transfer kind
	logic [1:0]  step_r, step_nxt;                // step of a software sequence
	logic [20:0] addr_r, addr_nxt;                // target word address
	logic [15:0] wdata_r, wdata_nxt;              // write data
	logic [1:0]  be_n_r, be_n_nxt;                // {upper, lower} lane disables
	logic [15:0] cfg_r, cfg_nxt;                  // config value to load
	logic [15:0] known_r, known_nxt;              // last config known in the device
	logic [1:0]  floor_r, floor_nxt;              // lowest allowed temperature rank
	logic [15:0] rdata_r, rdata_nxt;              // last word read
	logic        refused_r, refused_nxt;          // sticky refused-command flag
	logic [31:0] bus_r, bus_nxt;                  // software read data
	logic        ce_n_r, we_n_r, oe_n_r, lb_n_r, ub_n_r, zz_n_r, dq_oe_r;
	logic        ce_n_nxt, we_n_nxt, oe_n_nxt, lb_n_nxt, ub_n_nxt, zz_n_nxt, dq_oe_nxt;
	logic [20:0] pa_r, pa_nxt;                    // address pins
	logic [15:0] dq_r, dq_nxt;                    // data pins
	logic        sw_nxt, wr_nxt, wr_cur;          // operation decode
	logic        cmd_wr;                          // write to the command register
	logic        cfg_ok;                          // requested config is safe to load

	psram_timer u_tmr (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.t        (t)
	);

	// ****************************************************************
	// operation decode
	// ****************************************************************
	// software sequence reads on steps 0 and 1, writes on 2, then 3 by kind
	function automatic logic is_wr(input psram_pkg::kind_t k, input logic [1:0] s);
		is_wr = (k == psram_pkg::K_WR) || (k == psram_pkg::K_ZZCFG) ||
			((k == psram_pkg::K_SWWR) && s[1]) ||
			((k == psram_pkg::K_SWRD) && (s == 2'h2));
	endfunction

	assign cmd_wr = i_wr && (i_addr == `REG_CMD);
	// refuse temperatures below the floor, and deep powerdown by software
	assign cfg_ok = (psram_pkg::tcr_rank(cfg_r[`CFG_TCR_LO+1:`CFG_TCR_LO]) >= floor_r) &&
		!((i_wdata[2:0] == `CMD_SW_WR) && !cfg_r[`CFG_SLEEP_BIT]);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// one transfer or sequence at a time; commands while busy are refused
	always_comb begin
		state_nxt   = state_r;
		kind_nxt    = kind_r;
		step_nxt    = step_r;
		rdata_nxt   = rdata_r;
		known_nxt   = known_r;
		refused_nxt = refused_r;
		t.load      = 1'b0;
		t.value     = 12'(`ACC_CYC - 1);
		if (i_wr && (i_addr == `REG_STATUS) && i_wdata[`ST_REFUSED]) begin
			refused_nxt = 1'b0;                   // set below wins over this clear
		end
		unique case (state_r)
			psram_pkg::S_INIT: begin
				// chip select stays high until the interval ends
				if (t.done) begin
					state_nxt = psram_pkg::S_IDLE;
					known_nxt = `CFG_DEFAULT;
				end
			end
			psram_pkg::S_IDLE: begin
				if (cmd_wr) begin
					step_nxt = 2'h0;
					t.load   = 1'b1;
					unique case (i_wdata[2:0])
						`CMD_READ: begin
							kind_nxt  = psram_pkg::K_RD;
							state_nxt = psram_pkg::S_ACT;
						end
						`CMD_WRITE: begin
							kind_nxt  = psram_pkg::K_WR;
							state_nxt = psram_pkg::S_ACT;
						end
						`CMD_ZZ_CFG: begin
							kind_nxt    = psram_pkg::K_ZZCFG;
							state_nxt   = cfg_ok ? psram_pkg::S_ZZ_SET : psram_pkg::S_IDLE;
							refused_nxt = refused_nxt | !cfg_ok;
						end
						`CMD_SW_WR: begin
							kind_nxt    = psram_pkg::K_SWWR;
							state_nxt   = cfg_ok ? psram_pkg::S_ACT : psram_pkg::S_IDLE;
							refused_nxt = refused_nxt | !cfg_ok;
						end
						`CMD_SW_RD: begin
							kind_nxt  = psram_pkg::K_SWRD;
							state_nxt = psram_pkg::S_ACT;
						end
						`CMD_SLEEP: begin
							state_nxt = psram_pkg::S_ZZ_WAIT;
							t.value   = 12'(`SLEEP_CYC - 1);
						end
						default: begin
							refused_nxt = 1'b1;       // wake while awake, or no command
						end
					endcase
				end
			end
			psram_pkg::S_ZZ_SET: begin
				// sleep pin fell last cycle; the write follows at once
				state_nxt = psram_pkg::S_ACT;
				t.load    = 1'b1;
			end
			psram_pkg::S_ACT: begin
				// strobes low for the access time, well under the select limit
				if (t.done) begin
					state_nxt = psram_pkg::S_REC;
					if (!wr_cur) begin
						rdata_nxt = i_dq_in;
						if ((kind_r == psram_pkg::K_SWRD) && (step_r == 2'h3)) begin
							known_nxt = i_dq_in;
						end
					end
				end
			end
			psram_pkg::S_REC: begin
				// strobes rose last cycle, latching write data on that edge
				if (((kind_r == psram_pkg::K_SWWR) || (kind_r == psram_pkg::K_SWRD)) &&
					(step_r != 2'h3)) begin
					step_nxt  = step_r + 2'h1;
					state_nxt = psram_pkg::S_ACT;
					t.load    = 1'b1;
				end else begin
					state_nxt = psram_pkg::S_IDLE;
					if ((kind_r == psram_pkg::K_ZZCFG) || (kind_r == psram_pkg::K_SWWR)) begin
						known_nxt = cfg_r;
					end
				end
			end
			psram_pkg::S_ZZ_WAIT: begin
				if (t.done) begin
					state_nxt = psram_pkg::S_ASLEEP;
				end
			end
			psram_pkg::S_ASLEEP: begin
				// leaving deep powerdown costs a fresh initialisation
				if (cmd_wr && (i_wdata[2:0] == `CMD_WAKE)) begin
					if (!known_r[`CFG_SLEEP_BIT]) begin
						state_nxt = psram_pkg::S_INIT;
						t.load    = 1'b1;
						t.value   = 12'(`INIT_CYC - 1);
					end else begin
						state_nxt = psram_pkg::S_IDLE;
					end
				end
			end
		endcase
		if (cmd_wr && (state_r != psram_pkg::S_IDLE) && (state_r != psram_pkg::S_ASLEEP)) begin
			refused_nxt = 1'b1;
		end
	end

	// ****************************************************************
	// pins, from the state about to be entered
	// ****************************************************************
	// registered so every pin leaves a flip-flop cleanly
	always_comb begin
		sw_nxt    = (kind_nxt == psram_pkg::K_SWWR) || (kind_nxt == psram_pkg::K_SWRD);
		wr_nxt    = is_wr(kind_nxt, step_nxt);
		ce_n_nxt  = (state_nxt != psram_pkg::S_ACT);
		we_n_nxt  = !((state_nxt == psram_pkg::S_ACT) && wr_nxt);
		oe_n_nxt  = !((state_nxt == psram_pkg::S_ACT) && !wr_nxt);
		lb_n_nxt  = 1'b1;
		ub_n_nxt  = 1'b1;
		if (state_nxt == psram_pkg::S_ACT) begin
			// lanes are free for config loads; user lanes for data
			lb_n_nxt = (sw_nxt || (kind_nxt == psram_pkg::K_ZZCFG)) ? 1'b0 : be_n_r[0];
			ub_n_nxt = (sw_nxt || (kind_nxt == psram_pkg::K_ZZCFG)) ? 1'b0 : be_n_r[1];
		end
		dq_oe_nxt = ((state_nxt == psram_pkg::S_ACT) || (state_nxt == psram_pkg::S_REC)) &&
			wr_nxt && (kind_nxt != psram_pkg::K_ZZCFG);
		zz_n_nxt  = !((state_nxt == psram_pkg::S_ZZ_SET) || (state_nxt == psram_pkg::S_ZZ_WAIT) ||
			(state_nxt == psram_pkg::S_ASLEEP) || ((kind_nxt == psram_pkg::K_ZZCFG) &&
			((state_nxt == psram_pkg::S_ACT) || (state_nxt == psram_pkg::S_REC))));
		if (sw_nxt) begin
			pa_nxt = `SW_ADDR;
			dq_nxt = (step_nxt == 2'h2) ? `SW_STEP2_DATA : cfg_r;
		end else if (kind_nxt == psram_pkg::K_ZZCFG) begin
			pa_nxt = {5'h00, cfg_r};
			dq_nxt = 16'h0000;
		end else begin
			pa_nxt = addr_r;
			dq_nxt = wdata_r;
		end
	end

	// ****************************************************************
	// software registers
	// ****************************************************************
	// transfer registers are frozen while a transfer uses them
	always_comb begin
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		be_n_nxt  = be_n_r;
		cfg_nxt   = cfg_r;
		floor_nxt = floor_r;
		bus_nxt   = 32'h0000_0000;
		if (i_wr && ((state_r == psram_pkg::S_IDLE) || (state_r == psram_pkg::S_ASLEEP))) begin
			unique case (i_addr)
				`REG_ADDR:  addr_nxt = i_wdata[20:0];
				`REG_WDATA: begin
					wdata_nxt = i_wdata[15:0];
					be_n_nxt  = i_wdata[17:16];
				end
				`REG_CFG:   cfg_nxt = i_wdata[15:0];
				`REG_FLOOR: floor_nxt = i_wdata[1:0];
				default:    addr_nxt = addr_r;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				`REG_ADDR:   bus_nxt = {11'h000, addr_r};
				`REG_WDATA:  bus_nxt = {14'h0000, be_n_r, wdata_r};
				`REG_CFG:    bus_nxt = {16'h0000, cfg_r};
				`REG_STATUS: bus_nxt = {known_r, 12'h000, refused_r,
					state_r == psram_pkg::S_ASLEEP, state_r != psram_pkg::S_INIT,
					(state_r != psram_pkg::S_IDLE) && (state_r != psram_pkg::S_ASLEEP)};
				`REG_RDATA:  bus_nxt = {16'h0000, rdata_r};
				`REG_FLOOR:  bus_nxt = {30'h0000_0000, floor_r};
				default:     bus_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// state registers
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= psram_pkg::S_INIT;
			kind_r  <= psram_pkg::K_RD;
			step_r  <= 2'h0;
			addr_r  <= 21'h000000;
			wdata_r <= 16'h0000;
			be_n_r  <= 2'h0;
			cfg_r   <= `CFG_DEFAULT;
			known_r <= `CFG_DEFAULT;
			floor_r <= `FLOOR_DEFAULT;
			rdata_r <= 16'h0000;
			refused_r <= 1'b0;
			bus_r   <= 32'h0000_0000;
			ce_n_r  <= 1'b1;
			we_n_r  <= 1'b1;
			oe_n_r  <= 1'b1;
			lb_n_r  <= 1'b1;
			ub_n_r  <= 1'b1;
			zz_n_r  <= 1'b1;
			dq_oe_r <= 1'b0;
			pa_r    <= 21'h000000;
			dq_r    <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			kind_r  <= kind_nxt;
			step_r  <= step_nxt;
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			be_n_r  <= be_n_nxt;
			cfg_r   <= cfg_nxt;
			known_r <= known_nxt;
			floor_r <= floor_nxt;
			rdata_r <= rdata_nxt;
			refused_r <= refused_nxt;
			bus_r   <= bus_nxt;
			ce_n_r  <= ce_n_nxt;
			we_n_r  <= we_n_nxt;
			oe_n_r  <= oe_n_nxt;
			lb_n_r  <= lb_n_nxt;
			ub_n_r  <= ub_n_nxt;
			zz_n_r  <= zz_n_nxt;
			dq_oe_r <= dq_oe_nxt;
			pa_r    <= pa_nxt;
			dq_r    <= dq_nxt;
		end
	end

	assign wr_cur         = is_wr(kind_r, step_r);
	assign o_rdata        = bus_r;
	assign o_ce_n         = ce_n_r;
	assign o_we_n         = we_n_r;
	assign o_oe_n         = oe_n_r;
	assign o_lower_byte_n = lb_n_r;
	assign o_upper_byte_n = ub_n_r;
	assign o_sleep_n      = zz_n_r;
	assign o_mem_addr     = pa_r;
	assign o_dq_out       = dq_r;
	assign o_dq_oe        = dq_oe_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	localparam int SEL_MAX = `SEL_MAX_CYC;
	logic [7:0] sel_cnt_r;                        // cycles chip select has been low
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_cnt_r <= 8'h00;
		end else begin
			sel_cnt_r <= ce_n_r ? 8'h00 : sel_cnt_r + 8'h01;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	init_ce_high_a: assert property ((state_r == psram_pkg::S_INIT) |-> ce_n_r && zz_n_r)
		else $error("chip select low during initialisation");
	sel_low_max_a: assert property (sel_cnt_r <= SEL_MAX)
		else $error("chip select held low too long");
	read_pins_a: assert property (!oe_n_r |-> !ce_n_r && we_n_r && !dq_oe_r)
		else $error("bad read strobes");
	write_pins_a: assert property (!we_n_r && zz_n_r |-> !ce_n_r && oe_n_r && dq_oe_r)
		else $error("bad write strobes");
	data_hold_a: assert property ($rose(we_n_r) && zz_n_r |-> dq_oe_r && $stable(dq_r))
		else $error("write data changed at strobe rise");
	sw_addr_a: assert property ((state_r == psram_pkg::S_ACT) &&
		((kind_r == psram_pkg::K_SWWR) || (kind_r == psram_pkg::K_SWRD)) |-> pa_r == `SW_ADDR)
		else $error("software sequence off the top address");
	sw_order_a: assert property ((state_r == psram_pkg::S_ACT) && !step_r[1] &&
		((kind_r == psram_pkg::K_SWWR) || (kind_r == psram_pkg::K_SWRD)) |-> !oe_n_r)
		else $error("software sequence does not open with reads");
	no_sw_dpd_a: assert property ((state_r == psram_pkg::S_ACT) && (kind_r == psram_pkg::K_SWWR) &&
		(step_r == 2'h3) |-> dq_r[`CFG_SLEEP_BIT])
		else $error("software sequence selects deep powerdown");
	tcr_floor_a: assert property ((state_r == psram_pkg::S_ACT) && (kind_r == psram_pkg::K_SWWR) &&
		(step_r == 2'h3) |-> psram_pkg::tcr_rank(dq_r[6:5]) >= floor_r)
		else $error("refresh temperature below floor");
	zz_cfg_a: assert property ((state_r == psram_pkg::S_ACT) && (kind_r == psram_pkg::K_ZZCFG) |->
		!zz_n_r && !$past(zz_n_r) && !we_n_r)
		else $error("config load without sleep low");
	sleep_wait_a: assert property ($rose(state_r == psram_pkg::S_ASLEEP) |->
		!zz_n_r && !$past(zz_n_r, 8))
		else $error("asleep without sleep held low");
	idle_standby_a: assert property ((state_r == psram_pkg::S_IDLE) |-> ce_n_r && we_n_r && oe_n_r && zz_n_r)
		else $error("strobes active while idle");
endmodule
`default_nettype wire

// >>> design/psram_timer.sv
// loadable down counter that times every interval of the controller
`timescale 1ns/1ps
`default_nettype none
`include "psram_regs.svh"
module psram_timer (
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	tmr_if.timer      t
);
	logic [11:0] cnt_r;  // remaining cycles
	logic [11:0] cnt_nxt;

	// ****************************************************************
	// counter
	// ****************************************************************
	// reset starts the power-up interval so the sequencer waits from the first edge
	always_comb begin
		cnt_nxt = cnt_r;
		if (t.load) begin
			cnt_nxt = t.value;
		end else if (cnt_r != 12'h000) begin
			cnt_nxt = cnt_r - 12'h001;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_r <= 12'(`INIT_CYC - 1);
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign t.done = (cnt_r == 12'h000) && !t.load;
endmodule
`default_nettype wire

// >>> dv/psram_ctrl_tb.sv
// self-checking bench of the psram host controller against the memory model
`timescale 1ns/1ps
`default_nettype none
`include "psram_regs.svh"
module psram_ctrl_tb;
	logic        i_mclk, i_arst_n, i_wr, i_rd;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic        o_ce_n, o_we_n, o_oe_n, o_lower_byte_n, o_upper_byte_n, o_sleep_n, o_dq_oe;
	logic [20:0] o_mem_addr;
	logic [15:0] o_dq_out, dq_m, bus;
	int          bad_count = 0;
	int          n_checks = 0;
	// wire level: controller wins while it drives
	assign bus = o_dq_oe ? o_dq_out : dq_m;
	psram_ctrl u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
		.o_lower_byte_n(o_lower_byte_n), .o_upper_byte_n(o_upper_byte_n), .o_sleep_n(o_sleep_n),
		.o_mem_addr(o_mem_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(bus));
	psram_model u_mem (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .ce_n(o_ce_n), .we_n(o_we_n), .oe_n(o_oe_n),
		.lb_n(o_lower_byte_n), .ub_n(o_upper_byte_n), .sleep_n(o_sleep_n), .addr(o_mem_addr),
		.dq_w(bus), .dq(dq_m));
	// ****************************************
	// bus tasks and checks
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// poll status until the masked bits match, bounded
	task automatic wait_st(input logic [31:0] mask, input logic [31:0] val, input int lim);
		logic [31:0] s;
		for (int i = 0; i < lim; i++) begin
			rd(`REG_STATUS, s);
			if ((s & mask) === val) return;
		end
		chk(s & mask, val, "status wait timed out");
		test_done();
	endtask
	task automatic cmd(input logic [2:0] c);
		wr(`REG_CMD, {29'h0, c});
		wait_st(32'h3, 32'h2, 200);
	endtask
	task automatic refused(input string m);
		logic [31:0] s;
		rd(`REG_STATUS, s);
		chk({31'h0, s[3]}, 32'h1, m);
		wr(`REG_STATUS, 32'h8);
		rd(`REG_STATUS, s);
		chk({31'h0, s[3]}, 32'h0, "refused flag clear");
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_init();
		logic [31:0] s;
		rd(`REG_STATUS, s);
		chk({31'h0, s[1]}, 32'h0, "ready during init");
		wait_st(32'h2, 32'h2, 2000);
		rd(`REG_STATUS, s);
		chk({16'h0, s[31:16]}, 32'h0070, "config after init");
		chk(u_mem.viol, 0, "select during init");
	endtask
	task automatic s_rw();
		logic [31:0] d;
		wr(`REG_ADDR, 32'h5);
		wr(`REG_WDATA, 32'h0000A5C3);
		cmd(`CMD_WRITE);
		wr(`REG_WDATA, 32'h00011234);
		cmd(`CMD_WRITE);
		wr(`REG_WDATA, 32'h00000000);
		cmd(`CMD_READ);
		rd(`REG_RDATA, d);
		chk(d, 32'h12C3, "lane write");
		wr(`REG_WDATA, 32'h00020000);
		cmd(`CMD_READ);
		rd(`REG_RDATA, d);
		chk({24'h0, d[7:0]}, 32'hC3, "lower lane read");
		rd(8'h1C, d);
		chk(d, 32'h0, "unmapped read");
	endtask
	task automatic s_refuse();
		wr(`REG_CMD, 32'h0);
		refused("unknown code");
		wr(`REG_CMD, {29'h0, `CMD_WAKE});
		refused("wake while awake");
		wr(`REG_CMD, {29'h0, `CMD_READ});
		wr(`REG_CMD, {29'h0, `CMD_READ});
		refused("command while busy");
		wait_st(32'h3, 32'h2, 200);
	endtask
	task automatic s_cfg();
		logic [31:0] d;
		wr(`REG_CFG, 32'h00F0);
		cmd(`CMD_ZZ_CFG);
		chk({16'h0, u_mem.cfg_r}, 32'h00F0, "config by sleep pin");
		wr(`REG_CFG, 32'h0050);
		wr(`REG_CMD, {29'h0, `CMD_SW_WR});
		refused("low temperature");
		wr(`REG_CFG, 32'h0060);
		wr(`REG_CMD, {29'h0, `CMD_SW_WR});
		refused("software powerdown");
		wr(`REG_CMD, {29'h0, `CMD_SLEEP});
		wait_st(32'h4, 32'h4, 200);
		chk({31'h0, u_mem.asleep}, 32'h1, "partial refresh");
		cmd(`CMD_WAKE);
		cmd(`CMD_SW_RD);
		rd(`REG_RDATA, d);
		chk({16'h0, d[15:0]}, 32'h00F0, "software read");
		wr(`REG_CFG, 32'h00F1);
		cmd(`CMD_SW_WR);
		chk({15'h0, u_mem.lock, u_mem.cfg_r}, 32'h100F1, "software write");
		wr(`REG_CFG, 32'h0060);
		cmd(`CMD_ZZ_CFG);
		wr(`REG_CMD, {29'h0, `CMD_SLEEP});
		wait_st(32'h4, 32'h4, 200);
		wr(`REG_CMD, {29'h0, `CMD_WAKE});
		rd(`REG_STATUS, d);
		chk({31'h0, d[1]}, 32'h0, "init after powerdown");
		wait_st(32'h3, 32'h2, 2000);
	endtask
	// ****************************************
	// clock, reset and main sequence
	// ****************************************
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	initial begin
		{i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
		repeat (20) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		s_init();
		s_rw();
		s_refuse();
		s_cfg();
		chk(u_mem.viol, 0, "select low time");
		test_done();
	end
endmodule
`default_nettype wire

// >>> dv/psram_model.sv
// behavioural model of the async page psram seen from the controller pins
`timescale 1ns/1ps
`default_nettype none
module psram_model #(
	parameter int INIT_C  = 3000, // power-up interval in clock cycles
	parameter int SLP_C   = 200,  // sleep pin low time before a low-power mode
	parameter int MAX_LOW = 80    // longest allowed select low time in cycles
) (
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic        lb_n,
	input  wire logic        ub_n,
	input  wire logic        sleep_n,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] dq_w,
	output logic      [15:0] dq
);
	// ****************************************
	// state
	// ****************************************
	logic [15:0] mem [0:255];     // small array, low address byte only
	logic [15:0] cfg_r;           // configuration register
	logic [15:0] flt;             // floating pattern, changes every cycle
	logic [15:0] rv;              // word selected for a read
	logic        asleep, lock;    // low-power mode, software lock of sleep pin
	logic        pce, pwe, plb, pub, psl;
	logic [20:0] pa;
	logic [15:0] pd;
	int          init_c, slp_c, low_c, sw_step, viol;
	// ****************************************
	// pins sampled at the controller clock; a strobe rising ends an access
	// ****************************************
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_r <= 16'h0070;
			init_c <= INIT_C;
			// awake and unlocked after power-up; strobes idle high
			{asleep, lock, pce, pwe, plb, pub, psl} <= 7'h1F;
			{slp_c, low_c, sw_step, viol} <= 128'h0;
			flt <= 16'hA55A;
		end else begin
			flt <= ~flt;
			{pce, pwe, plb, pub, psl, pa, pd} <= {ce_n, we_n, lb_n, ub_n, sleep_n, addr, dq_w};
			if (init_c > 0) init_c <= init_c - 1;
			if (init_c > 0 && !ce_n) viol <= viol + 1;
			low_c <= ce_n ? 0 : low_c + 1;
			if (low_c > MAX_LOW) viol <= viol + 1;
			slp_c <= sleep_n ? 0 : slp_c + 1;
			// low-power entry; software lock only blocks the retaining mode
			if (slp_c == SLP_C && !sleep_n && !(lock && cfg_r[4])) begin
				asleep <= 1'b1;
				if (!cfg_r[4]) foreach (mem[i]) mem[i] <= ~mem[i];
			end
			if (sleep_n && asleep) begin
				asleep <= 1'b0;
				if (!cfg_r[4]) init_c <= INIT_C;
			end
			// write completes when chip select rises while write enable was still low
			if (ce_n && !pce && !pwe && init_c == 0 && !asleep) begin
				if (!psl) cfg_r <= pa[15:0];
				else if (pa == 21'h1FFFF && sw_step == 3) begin
					cfg_r <= pd;
					lock <= 1'b1;
					sw_step <= 0;
				end else if (pa == 21'h1FFFF && sw_step == 2) sw_step <= 3;
				else begin
					if (!plb) mem[pa[7:0]][7:0] <= pd[7:0];
					if (!pub) mem[pa[7:0]][15:8] <= pd[15:8];
					sw_step <= 0;
				end
			end
			if (ce_n && !pce && pwe) sw_step <= (pa == 21'h1FFFF && sw_step < 2) ? sw_step + 1 : 0;
		end
	end
	// ****************************************
	// read drive; every read is a full access, idle lanes float
	// ****************************************
	always_comb begin
		dq = flt;
		rv = (addr == 21'h1FFFF && sw_step == 3) ? cfg_r : mem[addr[7:0]];
		if (!ce_n && !oe_n && we_n && init_c == 0 && !asleep) begin
			if (!lb_n) dq[7:0] = rv[7:0];
			if (!ub_n) dq[15:8] = rv[15:8];
		end
	end
endmodule
`default_nettype wire

// >>> pkg/psram_pkg.sv
// types of the psram host controller
`default_nettype none
package psram_pkg;
	// controller sequencer states
	typedef enum logic [2:0] {
		S_INIT, S_IDLE, S_ZZ_SET, S_ACT, S_REC, S_ZZ_WAIT, S_ASLEEP
	} state_t;

	// kind of transfer in progress
	typedef enum logic [2:0] {
		K_RD, K_WR, K_ZZCFG, K_SWWR, K_SWRD
	} kind_t;

	// orders refresh temperature codes from coolest to hottest
	function automatic logic [1:0] tcr_rank(input logic [1:0] code);
		unique case (code)
			2'h2: tcr_rank = 2'h0;
			2'h1: tcr_rank = 2'h1;
			2'h0: tcr_rank = 2'h2;
			2'h3: tcr_rank = 2'h3;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> pkg/psram_regs.svh
// constants of the psram host controller: offsets, fields, commands, timing
`ifndef PSRAM_REGS_SVH
`define PSRAM_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CLK_NS        50
`define INIT_US       150
`define INIT_CYC      ((`INIT_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define SLEEP_US      10
`define SLEEP_CYC     ((`SLEEP_US * 1000) / `CLK_NS + 1)
`define ACC_NS        100
`define ACC_CYC       ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define SEL_MAX_NS    4000
`define SEL_MAX_CYC   (`SEL_MAX_NS / `CLK_NS)
`define TMR_W         12

// ****************************************************************
// device side constants
// ****************************************************************
`define SW_ADDR       21'h01FFFF
`define CFG_DEFAULT   16'h0070
`define CFG_SLEEP_BIT 4
`define CFG_TCR_LO    5
`define SW_STEP2_DATA 16'h0000

// ****************************************************************
// controller registers (byte offsets) and commands
// ****************************************************************
`define REG_CMD       8'h00
`define REG_ADDR      8'h04
`define REG_WDATA     8'h08
`define REG_CFG       8'h0C
`define REG_STATUS    8'h10
`define REG_RDATA     8'h14
`define REG_FLOOR     8'h18
`define FLOOR_DEFAULT 2'h3
`define ST_REFUSED    3
`define CMD_READ      3'h1
`define CMD_WRITE     3'h2
`define CMD_ZZ_CFG    3'h3
`define CMD_SW_WR     3'h4
`define CMD_SW_RD     3'h5
`define CMD_SLEEP     3'h6
`define CMD_WAKE      3'h7

`endif

// >>> pkg/tmr_if.sv
// load and done signals between the sequencer and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface tmr_if;
	logic        load;   // start a new interval
	logic [11:0] value;  // interval length minus one
	logic        done;   // interval elapsed

	modport master (output load, output value, input done);
	modport timer  (input load, input value, output done);
endinterface
`default_nettype wire
